// >>> rtl/switchgear_defs.svh
/*
  Constants for the switchgear control block: position codes, command
  sources, field widths and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SWITCHGEAR_DEFS_SVH
`define SWITCHGEAR_DEFS_SVH

// Position codes
`define POS_CODE_INDET 2'h0
`define POS_CODE_OPEN 2'h1
`define POS_CODE_CLOSED 2'h2
`define POS_CODE_DISTURBED 2'h3

// Earthing interpretation of the auxiliary inputs
`define EARTH_KIND_NONE 2'h0
`define EARTH_KIND_ON_AUX 2'h1
`define EARTH_KIND_OFF_AUX 2'h2

// Binary output source selections
`define RELAY_SRC_NONE 2'h0
`define RELAY_SRC_CLOSE 2'h1
`define RELAY_SRC_OPEN 2'h2
`define RELAY_SRC_TRIP 2'h3

// Field sizes
`define RELAY_ASSIGN_COUNT 7
`define INTERLOCK_COUNT 3
`define TRIP_SOURCE_COUNT 4
`define TIME_WIDTH 16
`define UNIT_WIDTH 4

// Ordinal of the unit that takes protection trips by default
`define FIRST_UNIT_NUMBER 4'h1

// Timer base: times are set in milliseconds
`define TICK_TIME_NS 1000000
`define CLK_PERIOD_NS 8
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)

// Reset values
`define TIMER_RESET 16'h0000

`endif

// >>> rtl/switchgear_pkg.sv
/*
  Types for the switchgear control block: states, position codes and the
  configuration carrier.
  Assumes switchgear_defs.svh is on the include path.
*/
`include "switchgear_defs.svh"

package switchgear_pkg;

  typedef enum logic [1:0] {
    POS_INDET = `POS_CODE_INDET,
    POS_OPEN = `POS_CODE_OPEN,
    POS_CLOSED = `POS_CODE_CLOSED,
    POS_DISTURBED = `POS_CODE_DISTURBED
  } pos_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_CLOSING = 4'h4,
    ST_OPENING = 4'h8
  } sg_state_e;

  typedef logic [`TIME_WIDTH-1:0] time_t;

  // Per-switchgear configuration, static while operating
  typedef struct packed {
    logic controlled;
    logic break_capable;
    logic invisible;
    logic latched;
    logic gen_to_grid_sync_mode;
    logic [1:0] earth_kind;
    logic [`UNIT_WIDTH-1:0] unit_number;
    time_t t_move_on;
    time_t t_move_off;
    time_t trip_min_hold_time;
    time_t sync_supervision_limit;
    logic [`RELAY_ASSIGN_COUNT-1:0][1:0] relay_sel;
  } sg_config_s;

  // Decoded auxiliary contact state
  typedef struct packed {
    pos_e pos;
    logic earthed;
    logic ready;
    logic removed;
  } sg_status_s;

endpackage

// >>> rtl/position_decoder.sv
/*
  Decodes the closed and open auxiliary contacts into a position code
  and registers the ready, removed and earthed indications.
  Assumes contact inputs are already synchronous to clk_in.
*/
`timescale 1ns/1ns
`include "switchgear_defs.svh"

module position_decoder
  import switchgear_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Contacts and interpretation
  input wire logic aux_closed_in,
  input wire logic aux_open_in,
  input wire logic ready_in,
  input wire logic removed_in,
  input wire logic [1:0] earth_kind_in,
  // Decoded state
  output sg_status_s status_out
);

  pos_e next_pos;

  // Both contacts true is implausible, neither is travel
  always_comb
  begin
    case ({aux_closed_in, aux_open_in})
      2'b10: next_pos = POS_CLOSED;
      2'b01: next_pos = POS_OPEN;
      2'b11: next_pos = POS_DISTURBED;
      default: next_pos = POS_INDET;
    endcase
  end

  // Registered status
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_out <= '{pos: POS_INDET, earthed: 1'b0, ready: 1'b0,
                      removed: 1'b0};
    end
    else if (ce_in)
    begin
      status_out.pos <= next_pos;
      status_out.ready <= ready_in;
      status_out.removed <= removed_in;
      status_out.earthed <=
        (earth_kind_in == `EARTH_KIND_ON_AUX && aux_closed_in) ||
        (earth_kind_in == `EARTH_KIND_OFF_AUX && aux_open_in);
    end
  end

endmodule

// >>> rtl/ms_countdown.sv
/*
  Millisecond down-counter used for travel, trip hold and sync supervision.
  Assumes tick_in is a one-cycle strobe once per millisecond.
*/
`timescale 1ns/1ns
`include "switchgear_defs.svh"

module ms_countdown
  import switchgear_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  // Control
  input wire logic start_in,
  input wire logic stop_in,
  input wire time_t limit_in,
  // State
  output logic running_out,
  output logic expired_out
);

  time_t count;

  // A limit of zero still waits for one tick
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= `TIMER_RESET;
      running_out <= 1'b0;
      expired_out <= 1'b0;
    end
    else if (ce_in)
    begin
      expired_out <= 1'b0;
      if (start_in)
      begin
        count <= limit_in;
        running_out <= 1'b1;
      end
      else if (stop_in)
        running_out <= 1'b0;
      else if (running_out && tick_in)
      begin
        if (count <= 16'h0001)
        begin
          running_out <= 1'b0;
          expired_out <= 1'b1;
        end
        else
          count <= count - 16'h0001;
      end
    end
  end

endmodule

// >>> rtl/switchgear_control.sv
/*
  Control and supervision of one switchgear: position reporting, gated
  close/open commands with interlocks and travel supervision, trip
  manager with minimum hold and latching, sync supervision, and a
  seven-way binary output assignment.
  Assumes all inputs are synchronous to clk_in and configuration is
  static while commands run.
*/
`timescale 1ns/1ns
`include "switchgear_defs.svh"

module switchgear_control
  import switchgear_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Configuration
  input wire sg_config_s config_in,
  // Auxiliary contacts
  input wire logic aux_closed_in,
  input wire logic aux_open_in,
  input wire logic ready_in,
  input wire logic removed_in,
  // Manual commands, local panel or remote
  input wire logic manual_close_in,
  input wire logic manual_open_in,
  input wire logic manual_from_panel_in,
  input wire logic remote_close_in,
  input wire logic remote_open_in,
  input wire logic [`UNIT_WIDTH-1:0] remote_unit_in,
  // External requests and interlocks
  input wire logic external_close_request_in,
  input wire logic external_open_request_in,
  input wire logic [`INTERLOCK_COUNT-1:0] close_interlock_signal_in,
  input wire logic [`INTERLOCK_COUNT-1:0] open_interlock_signal_in,
  // Trip manager
  input wire logic [`TRIP_SOURCE_COUNT-1:0] trip_source_signal_in,
  input wire logic protection_trip_in,
  input wire logic trip_release_ack_in,
  input wire logic sync_ok_in,
  // Status
  output logic [1:0] position_out,
  output logic earthed_out,
  output logic ready_out,
  output logic removed_out,
  output logic cmd_rejected_out,
  output logic cmd_failed_out,
  output logic sync_timeout_out,
  output logic config_valid_out,
  // Commands to the coils
  output logic close_cmd_out,
  output logic open_cmd_out,
  output logic trip_cmd_out,
  output logic relay_out
);

  sg_status_s status;
  sg_state_e state;
  sg_state_e next_state;
  logic [16:0] tick_count;
  logic tick;
  logic is_first_unit;
  logic trip_cause;
  logic trip_cause_q;
  logic trip_latch;
  logic close_req;
  logic open_req;
  logic close_blocked;
  logic open_blocked;
  logic local_ok;
  logic remote_hit;
  logic fail_disturb;
  logic start_close;
  logic start_open;
  logic start_sync;
  logic travel_start;
  logic travel_expired;
  logic hold_running;
  logic sync_running;
  logic sync_expired;
  logic trip_now;
  logic [`RELAY_ASSIGN_COUNT-1:0] relay_hit;
  time_t travel_limit;

  // Contact decoding
  position_decoder decoder (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .aux_closed_in(aux_closed_in),
    .aux_open_in(aux_open_in),
    .ready_in(ready_in),
    .removed_in(removed_in),
    .earth_kind_in(config_in.earth_kind),
    .status_out(status)
  );

  // Millisecond strobe shared by all timers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_count <= 17'h00000;
      tick <= 1'b0;
    end
    else if (ce_in)
    begin
      tick <= (tick_count == 17'(TICK_CYCLES - 1));
      if (tick_count == 17'(TICK_CYCLES - 1))
        tick_count <= 17'h00000;
      else
        tick_count <= tick_count + 17'h00001;
    end
  end

  // Command gating from configuration and sources
  always_comb
  begin
    is_first_unit = (config_in.unit_number == `FIRST_UNIT_NUMBER);
    local_ok = !(manual_from_panel_in && config_in.invisible);
    remote_hit = (remote_unit_in == config_in.unit_number);
    close_req = config_in.controlled &&
      ((manual_close_in && local_ok) ||
       (remote_close_in && remote_hit) ||
       external_close_request_in);
    open_req = config_in.controlled &&
      ((manual_open_in && local_ok) ||
       (remote_open_in && remote_hit) ||
       external_open_request_in);
    close_blocked = |close_interlock_signal_in;
    open_blocked = |open_interlock_signal_in;
    trip_cause = config_in.break_capable &&
      ((|trip_source_signal_in) ||
       (protection_trip_in && is_first_unit));
  end

  // Command sequencer: open has priority, a trip aborts a sync or a close but not an open
  always_comb
  begin
    next_state = state;
    start_close = 1'b0;
    start_open = 1'b0;
    start_sync = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (trip_now)
          next_state = ST_IDLE;
        else if (open_req && !open_blocked)
        begin
          next_state = ST_OPENING;
          start_open = 1'b1;
        end
        else if (close_req && !close_blocked)
        begin
          if (config_in.gen_to_grid_sync_mode && config_in.break_capable)
          begin
            next_state = ST_SYNC;
            start_sync = 1'b1;
          end
          else
          begin
            next_state = ST_CLOSING;
            start_close = 1'b1;
          end
        end
      end
      ST_SYNC:
      begin
        if (trip_now || sync_expired)
          next_state = ST_IDLE;
        else if (sync_ok_in)
        begin
          next_state = ST_CLOSING;
          start_close = 1'b1;
        end
      end
      ST_CLOSING:
      begin
        if (trip_now || travel_expired || status.pos == POS_CLOSED)
          next_state = ST_IDLE;
      end
      ST_OPENING:
      begin
        if (travel_expired || status.pos == POS_OPEN)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    travel_start = start_close || start_open;
    travel_limit = start_close ? config_in.t_move_on :
                   config_in.t_move_off;
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= ST_IDLE;
    else if (ce_in)
      state <= next_state;
  end

  // Travel supervision, one shared timer loaded with the limit for the direction
  ms_countdown travel_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(travel_start),
    .stop_in(next_state == ST_IDLE),
    .limit_in(travel_limit),
    .running_out(),
    .expired_out(travel_expired)
  );

  // Synchronizing supervision window
  ms_countdown sync_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(start_sync),
    .stop_in(state != ST_SYNC),
    .limit_in(config_in.sync_supervision_limit),
    .running_out(sync_running),
    .expired_out(sync_expired)
  );

  // Minimum trip hold, restarted when the combined trip cause rises from idle
  ms_countdown hold_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(trip_cause && !trip_cause_q),
    .stop_in(1'b0),
    .limit_in(config_in.trip_min_hold_time),
    .running_out(hold_running),
    .expired_out()
  );

  // Trip stays up while caused, held or latched
  assign trip_now = trip_cause || hold_running || trip_latch;

  // Latch: a new cause wins over a simultaneous acknowledge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      trip_cause_q <= 1'b0;
      trip_latch <= 1'b0;
    end
    else if (ce_in)
    begin
      trip_cause_q <= trip_cause;
      if (trip_cause && config_in.latched)
        trip_latch <= 1'b1;
      else if (trip_release_ack_in || !config_in.latched)
        trip_latch <= 1'b0;
    end
  end

  // Failure flag forces the disturbed code until the next command
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fail_disturb <= 1'b0;
      sync_timeout_out <= 1'b0;
      cmd_rejected_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (travel_expired)
        fail_disturb <= 1'b1;
      else if (travel_start)
        fail_disturb <= 1'b0;
      if (sync_expired)
        sync_timeout_out <= 1'b1;
      else if (start_sync)
        sync_timeout_out <= 1'b0;
      cmd_rejected_out <= state == ST_IDLE && !trip_now &&
        ((open_req && open_blocked) ||
         (close_req && close_blocked && !(open_req && !open_blocked)));
    end
  end

  // Per-assignment source match for the binary output
  genvar i;
  generate
    for (i = 0; i < `RELAY_ASSIGN_COUNT; i = i + 1)
    begin : g_relay
      always_comb
      begin
        case (config_in.relay_sel[i])
          `RELAY_SRC_CLOSE: relay_hit[i] = next_state == ST_CLOSING;
          `RELAY_SRC_OPEN: relay_hit[i] = next_state == ST_OPENING;
          `RELAY_SRC_TRIP: relay_hit[i] = trip_now;
          default: relay_hit[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      position_out <= `POS_CODE_INDET;
      earthed_out <= 1'b0;
      ready_out <= 1'b0;
      removed_out <= 1'b0;
      cmd_failed_out <= 1'b0;
      config_valid_out <= 1'b0;
      close_cmd_out <= 1'b0;
      open_cmd_out <= 1'b0;
      trip_cmd_out <= 1'b0;
      relay_out <= 1'b0;
    end
    else if (ce_in)
    begin
      position_out <= (fail_disturb || travel_expired) ?
                      POS_DISTURBED : status.pos;
      earthed_out <= status.earthed;
      ready_out <= status.ready;
      removed_out <= status.removed;
      cmd_failed_out <= fail_disturb || travel_expired;
      config_valid_out <= !is_first_unit ||
                          config_in.break_capable;
      close_cmd_out <= next_state == ST_CLOSING;
      open_cmd_out <= next_state == ST_OPENING;
      trip_cmd_out <= trip_now;
      relay_out <= config_in.controlled && (|relay_hit);
    end
  end

endmodule

// >>> bench/sg_chk.sv
/*
  Concurrent checks on the switchgear control ports, bound to its top.
  Assumes ce_in is held high and one tick is TICK_CYCLES clocks.
*/
`timescale 1ns/1ns
`include "switchgear_defs.svh"
module sg_chk
  import switchgear_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire sg_config_s config_in,
  input wire logic aux_closed_in,
  input wire logic aux_open_in,
  input wire logic ready_in,
  input wire logic removed_in,
  input wire logic [`INTERLOCK_COUNT-1:0] close_interlock_signal_in,
  input wire logic [`INTERLOCK_COUNT-1:0] open_interlock_signal_in,
  input wire logic [`TRIP_SOURCE_COUNT-1:0] trip_source_signal_in,
  input wire logic trip_release_ack_in,
  // Watched outputs
  input wire logic [1:0] position_out,
  input wire logic ready_out,
  input wire logic removed_out,
  input wire logic cmd_rejected_out,
  input wire logic cmd_failed_out,
  input wire logic sync_timeout_out,
  input wire logic config_valid_out,
  input wire logic close_cmd_out,
  input wire logic open_cmd_out,
  input wire logic trip_cmd_out,
  input wire logic relay_out
);
  logic [1:0] live;

  // Edges since reset; decoded levels lag two edges, so wait for three
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      live <= 2'h0;
    else if (live != 2'h3)
      live <= live + 2'h1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_both_disturbed: assert property (
    live == 2'h3 && $past(aux_closed_in && aux_open_in, 2)
    |-> position_out == POS_DISTURBED) else $error("both contacts shown");
  a_closed_pos: assert property (
    live == 2'h3 && !cmd_failed_out && $past(aux_closed_in && !aux_open_in, 2)
    |-> position_out == POS_CLOSED) else $error("closed contact not shown");
  a_ready_removed: assert property (
    live == 2'h3 |-> ready_out == $past(ready_in, 2)
    && removed_out == $past(removed_in, 2))
    else $error("flag does not follow");
  a_close_locked: assert property (
    $rose(close_cmd_out) |-> $past(close_interlock_signal_in) == 3'h0)
    else $error("close issued while interlocked");
  a_open_locked: assert property (
    $rose(open_cmd_out) |-> $past(open_interlock_signal_in) == 3'h0)
    else $error("open issued while interlocked");
  a_trip_follow: assert property (
    config_in.break_capable && trip_source_signal_in != 4'h0 |=> trip_cmd_out)
    else $error("trip source not followed");
  a_trip_capable: assert property (
    !config_in.break_capable && $stable(config_in) |-> !trip_cmd_out)
    else $error("trip on unit without break capability");
  a_uncontrolled_quiet: assert property (
    !config_in.controlled && $stable(config_in)
    |-> !close_cmd_out && !open_cmd_out && !relay_out)
    else $error("command on uncontrolled unit");
  a_trip_hold: assert property (
    TICK_CYCLES == 4 && config_in.trip_min_hold_time == 16'h0003
    && $rose(trip_cmd_out) |-> trip_cmd_out [*8])
    else $error("trip too short");
  a_latch_kept: assert property (
    config_in.latched && trip_cmd_out && !trip_release_ack_in |=> trip_cmd_out)
    else $error("latched trip dropped");
  a_config_check: assert property (
    live == 2'h3 && $stable(config_in) |-> config_valid_out ==
    !(config_in.unit_number == 4'h1 && !config_in.break_capable))
    else $error("config valid flag wrong");
  a_travel_fail: assert property (
    $rose(cmd_failed_out) |-> position_out == POS_DISTURBED
    && !close_cmd_out && !open_cmd_out) else $error("failure not reported");

  // Main scenarios reached
  c_close: cover property ($rose(close_cmd_out));
  c_reject: cover property ($rose(cmd_rejected_out));
  c_fail: cover property ($rose(cmd_failed_out));
  c_sync: cover property ($rose(sync_timeout_out));
endmodule

bind switchgear_control sg_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_in, .rst_in, .config_in, .aux_closed_in, .aux_open_in, .ready_in,
  .removed_in, .close_interlock_signal_in, .open_interlock_signal_in,
  .trip_source_signal_in, .trip_release_ack_in, .position_out, .ready_out,
  .removed_out, .cmd_rejected_out, .cmd_failed_out, .sync_timeout_out,
  .config_valid_out, .close_cmd_out, .open_cmd_out, .trip_cmd_out,
  .relay_out);

// >>> bench/breaker_model.sv
/*
  Behavioural breaker: coils move the contacts after a travel time.
  Assumes coil levels from the control block; the bench may freeze or
  override the contacts.
*/
`timescale 1ns/1ns
module breaker_model
#(
  parameter int TRAVEL = 5
)
(
  // Clock
  input wire logic clk_in,
  // Coils
  input wire logic close_coil_in,
  input wire logic open_coil_in,
  input wire logic trip_coil_in,
  // Scenario control
  input wire logic stuck_in,
  input wire logic force_in,
  input wire logic [1:0] force_val_in,
  // Contacts
  output logic aux_closed_out,
  output logic aux_open_out
);
  logic closed = 1'b0;
  logic want;
  int travel = 0;

  // Opening coils win; a stuck mechanism never moves
  assign want = close_coil_in && !open_coil_in && !trip_coil_in;
  always @(posedge clk_in)
  begin
    if (stuck_in || !(close_coil_in || open_coil_in || trip_coil_in))
      travel <= 0;
    else if (travel == TRAVEL)
    begin
      closed <= want;
      travel <= 0;
    end
    else if (want != closed)
      travel <= travel + 1;
  end

  // Both contacts drop while moving, like a real mid-travel mechanism
  assign aux_closed_out = force_in ? force_val_in[1] :
                          closed && travel == 0;
  assign aux_open_out = force_in ? force_val_in[0] :
                        !closed && travel == 0;
endmodule

// >>> bench/tb.sv
/*
  Self-checking bench for switchgear_control with a breaker model.
  Assumes a tick of 4 clocks and ce_in tied high.
*/
`timescale 1ns/1ns
`include "switchgear_defs.svh"
module tb;
  import switchgear_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  sg_config_s cfg;
  logic mc, mo, pnl, rc, ro, ec, eo, ack, sok, ptrip, rdy, rmv, stk, frc;
  logic [3:0] ru, ts;
  logic [2:0] ci, oi;
  logic [1:0] fv, pos;
  logic aux_c, aux_o, eth, rdy_o, rmv_o, rej, fail, stmo, cval;
  logic cc, oc, tc, rel;
  logic [4:0] obs;
  logic [31:0] seed = 32'h0000c893;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n;

  switchgear_control #(.TICK_CYCLES(4)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .config_in(cfg),
    .aux_closed_in(aux_c), .aux_open_in(aux_o), .ready_in(rdy),
    .removed_in(rmv), .manual_close_in(mc), .manual_open_in(mo),
    .manual_from_panel_in(pnl), .remote_close_in(rc), .remote_open_in(ro),
    .remote_unit_in(ru), .external_close_request_in(ec),
    .external_open_request_in(eo), .close_interlock_signal_in(ci),
    .open_interlock_signal_in(oi), .trip_source_signal_in(ts),
    .protection_trip_in(ptrip), .trip_release_ack_in(ack), .sync_ok_in(sok),
    .position_out(pos), .earthed_out(eth), .ready_out(rdy_o),
    .removed_out(rmv_o), .cmd_rejected_out(rej), .cmd_failed_out(fail),
    .sync_timeout_out(stmo), .config_valid_out(cval), .close_cmd_out(cc),
    .open_cmd_out(oc), .trip_cmd_out(tc), .relay_out(rel));
  breaker_model #(.TRAVEL(5)) brk (
    .clk_in(clk_in), .close_coil_in(cc), .open_coil_in(oc), .trip_coil_in(tc),
    .stuck_in(stk), .force_in(frc), .force_val_in(fv),
    .aux_closed_out(aux_c), .aux_open_out(aux_o));
  assign obs = {stmo, fail, tc, oc, cc};

  // Clock and hang guard; the ceiling is far above the planned run
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [1:0] pos_exp(input logic c, input logic o);
    return {c, o};
  endfunction
  function automatic logic earth_exp(input logic [1:0] k, input logic c,
                                     input logic o);
    return (k == 2'h1) ? c : (k == 2'h2) ? o : 1'b0;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  // Waits, bounded, for one observed output to reach a level
  task automatic wt(input int i, input logic v, input int lim, output int k);
    k = 0;
    while (obs[i] !== v && k < lim)
    begin
      cyc(1);
      k++;
    end
  endtask
  // One-cycle request from manual, remote or external source
  task automatic req(input int s, input logic d);
    if (s == 0) {mo, mc} = {d, !d};
    else if (s == 1) {ro, rc} = {d, !d};
    else {eo, ec} = {d, !d};
    cyc(1);
    {mo, mc, ro, rc, eo, ec} = 6'h00;
  endtask
  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    cfg = '0;
    {mc, mo, pnl, rc, ro, ec, eo, ack, sok, ptrip, rdy, rmv, stk} = 13'h0000;
    {ru, ts, ci, oi, fv, frc} = 17'h00000;
    cyc(3);
    chk({pos, cc, oc, tc}, 5'h00);
    cyc(1);
    rst_in = 1'b0;
    // Contact decoding, earthing kinds and flags, random flags
    frc = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      {rdy, rmv} = seed[1:0];
      fv = 2'(i);
      cfg.earth_kind = 2'(i / 4);
      cyc(3);
      chk(pos, pos_exp(fv[1], fv[0]));
      chk(eth, earth_exp(cfg.earth_kind, fv[1], fv[0]));
      chk({rdy_o, rmv_o}, {rdy, rmv});
    end
    frc = 1'b0;
    cfg = '0;
    cfg.controlled = 1'b1;
    cfg.break_capable = 1'b1;
    cfg.unit_number = 4'h2;
    ru = 4'h2;
    cfg.t_move_on = 16'h0004;
    cfg.t_move_off = 16'h0006;
    cfg.relay_sel[6] = `RELAY_SRC_CLOSE;
    cyc(3);
    // Every request source, close then open
    for (int s = 0; s < 6; s++)
    begin
      cfg.relay_sel[6] = s[1] ? `RELAY_SRC_OPEN : `RELAY_SRC_CLOSE;
      req(s / 2, s[0]);
      chk({cc, oc, rel}, {!s[0], s[0], s[0] == s[1]});
      wt(s[0], 1'b0, 30, n);
      cyc(2);
      chk(pos, pos_exp(!s[0], s[0]));
    end
    // Each interlock bit refuses its command
    for (int k = 0; k < 6; k++)
    begin
      {oi, ci} = 6'h01 << k;
      req(0, k / 3);
      chk({rej, cc, oc}, 3'h4);
      {oi, ci} = 6'h00;
      cyc(12);
    end
    // Wrong ordinal, panel on invisible, uncontrolled; then accepted case
    for (int j = 0; j < 4; j++)
    begin
      ru = (j == 0) ? 4'h3 : 4'h2;
      cfg.invisible = j > 0;
      pnl = j == 1;
      cfg.controlled = j != 2;
      cyc(1);
      req(j == 0, 1'b0);
      cyc(1);
      chk(cc, j == 3);
    end
    wt(0, 1'b0, 30, n);
    cfg.invisible = 1'b0;
    pnl = 1'b0;
    // Stuck breaker never opens; forced open contacts never show closed
    stk = 1'b1;
    for (int d = 1; d >= 0; d--)
    begin
      frc = !d[0];
      fv = 2'h1;
      req(0, d[0]);
      // Old failure flag drops one edge after the new start
      cyc(1);
      wt(3, 1'b1, 40, n);
      chk(n >= (d ? 21 : 13) && n <= (d ? 24 : 16), 1'b1);
      chk({pos, cc, oc}, 4'hc);
    end
    stk = 1'b0;
    frc = 1'b0;
    // Trip from a random source, then latched until acknowledged
    cfg.trip_min_hold_time = 16'h0003;
    cfg.relay_sel[6] = `RELAY_SRC_TRIP;
    for (int l = 0; l < 2; l++)
    begin
      cfg.latched = l[0];
      seed = xs(seed);
      ts = 4'h1 << seed[1:0];
      cyc(1);
      ts = 4'h0;
      wt(2, 1'b1, 4, n);
      chk({tc, rel}, 2'h3);
      if (l == 0)
      begin
        wt(2, 1'b0, 30, n);
        chk(n >= 6 && n <= 14, 1'b1);
      end
      else
      begin
        cyc(30);
        chk(tc, 1'b1);
        ack = 1'b1;
        cyc(2);
        chk(tc, 1'b0);
        ack = 1'b0;
      end
    end
    cfg.latched = 1'b0;
    // Protection trip reaches only unit one
    for (int u = 1; u < 3; u++)
    begin
      cfg.unit_number = 4'(u);
      ptrip = 1'b1;
      cyc(2);
      ptrip = 1'b0;
      chk(tc, u == 1);
      cyc(20);
    end
    cfg.unit_number = 4'h1;
    cfg.break_capable = 1'b0;
    ts = 4'h8;
    cyc(2);
    chk({cval, tc}, 2'h0);
    ts = 4'h0;
    cfg.break_capable = 1'b1;
    cyc(2);
    chk(cval, 1'b1);
    // Synchronizing close: supervision expiry, then a matched close
    cfg.gen_to_grid_sync_mode = 1'b1;
    cfg.sync_supervision_limit = 16'h0003;
    req(0, 1'b0);
    wt(4, 1'b1, 30, n);
    chk({n >= 6 && n <= 15, cc}, 2'h2);
    sok = 1'b1;
    req(0, 1'b0);
    wt(0, 1'b1, 6, n);
    chk(cc, 1'b1);
    wt(0, 1'b0, 30, n);
    close_out();
  end
endmodule
